/* File: verilog/msr_startup_regs.sv */
// Module: reverse-drive and start-up settings registers with their own timing logic
//
// Notes on behaviour
// RQ1 - Reverse-drive word at byte offset 38h, all zeros after reset.
// RQ2 - Start-up word at byte offset 3Ch, all zeros after reset.
// RQ3 - Bit 28: zero uses forward settings in reverse, one uses reverse settings.
// RQ4 - Bits 27-24: reverse linear acceleration code, 0.01Hz/s up to 10000Hz/s.
// RQ5 - Bits 23-20: reverse quadratic acceleration code, 0.0Hz/s2 up to 10000Hz/s2.
// RQ6 - Bits 31-30: single hold, double hold, pulse detection, slow first cycle.
// RQ7 - Bits 29-26: current ramp rate code; code Fh means no ramp limit.
// RQ8 - Bits 25-22: orientation hold time code, 10ms up to 10s.
// RQ9 - Bits 21-17: hold current limit code, 7.5% to 100% of base.
// RQ10 - Bits 16-14: detection pulse rate code, 50Hz up to 10000Hz.
// RQ11 - Bits 13-7: detection threshold, value times base current over 128.
// RQ12 - Bit 6: phases braked (0) or tristated (1) after detection.
// RQ13 - Bits 5-4: advance angle after detection, 0, 30, 60 or 90 degrees.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module msr_startup_regs #(
  parameter int P_CLK_HZ = 10000000
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [msr_pkg::MSR_ADDR_W-1:0] i_addr,
  input wire logic [msr_pkg::MSR_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [msr_pkg::MSR_DATA_W-1:0] o_rdata,
  input wire logic i_reverse_active,
  input wire logic [4:0] i_fwd_open_loop_current,
  input wire logic [3:0] i_fwd_linear_accel_coef,
  input wire logic [3:0] i_fwd_quadratic_accel_coef,
  input wire logic [4:0] i_rev_open_loop_current,
  input wire logic i_hold_start,
  input wire logic i_position_detect_run,
  input wire logic [6:0] i_phase_current_frac,
  output logic [4:0] o_eff_open_loop_current,
  output logic [3:0] o_eff_linear_accel_coef,
  output logic [3:0] o_eff_quadratic_accel_coef,
  output logic o_reverse_param_source_sel,
  output logic [1:0] o_startup_method_sel,
  output logic o_method_single_hold,
  output logic o_method_double_hold,
  output logic o_method_pulse_detect,
  output logic o_method_slow_cycle,
  output logic [3:0] o_ramp_rate_code,
  output logic o_ramp_unlimited,
  output logic [3:0] o_hold_time_code,
  output logic [4:0] o_hold_current_limit,
  output logic [2:0] o_position_pulse_frequency,
  output logic [6:0] o_position_pulse_current_threshold,
  output logic o_position_release_style,
  output logic [1:0] o_position_advance_angle,
  output logic [6:0] o_position_advance_deg,
  output logic [3:0] o_startup_low_bits,
  output logic o_hold_busy,
  output logic o_hold_done,
  output logic o_position_pulse,
  output logic o_position_over_threshold
);
  import msr_pkg::*;

  typedef enum logic [1:0] {
    MSR_HOLD_IDLE,
    MSR_HOLD_RUN,
    MSR_HOLD_END
  } msr_hold_state_t;

  // Cycles per millisecond, derived from the clock rate
  localparam int MS_CYCLES_INT = P_CLK_HZ / (MSR_US_PER_S / MSR_MS_TIME_US);
  localparam logic [31:0] MS_CYCLES = MS_CYCLES_INT[31:0];

  // Field extraction, used for both the reverse and the start-up register word
  function automatic logic [3:0] field4(input logic [31:0] word, input int lsb);
    field4 = word[lsb +: 4];
  endfunction : field4

  logic [31:0] reverse_reg;
  logic [31:0] reverse_next;
  logic [31:0] startup_reg;
  logic [31:0] startup_next;
  logic [31:0] rdata_next;
  logic [31:0] status_word;

  logic sel_reverse;
  logic sel_startup;
  logic sel_status;
  logic wr_reverse;
  logic wr_startup;

  // Address decode
  assign sel_reverse = (i_addr == MSR_REVERSE_OFS);
  assign sel_startup = (i_addr == MSR_STARTUP_OFS);
  assign sel_status = (i_addr == MSR_STATUS_OFS);
  assign wr_reverse = i_wr && sel_reverse;
  assign wr_startup = i_wr && sel_startup;

  // Reserved bits of the reverse word stay zero
  assign reverse_next = wr_reverse ? (i_wdata & MSR_REVERSE_WMASK) : reverse_reg;
  assign startup_next = wr_startup ? (i_wdata & MSR_STARTUP_WMASK) : startup_reg;

  // Unmapped addresses read zero; data valid only in the cycle after the strobe
  assign rdata_next = !i_rd ? 32'h0000_0000 :
                      sel_reverse ? reverse_reg :
                      sel_startup ? startup_reg :
                      sel_status ? status_word : 32'h0000_0000;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      reverse_reg <= MSR_REVERSE_RST; // see RQ1
      startup_reg <= MSR_STARTUP_RST; // see RQ2
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      reverse_reg <= reverse_next; // see RQ1
      startup_reg <= startup_next; // see RQ2
      o_rdata <= rdata_next;
    end
  end

  // Field views of the reverse word
  logic rev_src_sel;
  logic [3:0] rev_lin;
  logic [3:0] rev_quad;

  assign rev_src_sel = reverse_reg[MSR_REV_SRC_BIT];
  assign rev_lin = field4(reverse_reg, MSR_REV_LIN_LSB); // see RQ4
  assign rev_quad = field4(reverse_reg, MSR_REV_QUAD_LSB); // see RQ5

  // Field views of the start-up word
  logic [1:0] method;
  logic [3:0] ramp;
  logic [3:0] hold_code;
  logic [4:0] hold_ilim;
  logic [2:0] freq_code;
  logic [6:0] thr;
  logic rls;
  logic [1:0] adv;

  assign method = startup_reg[MSR_METHOD_LSB +: 2];
  assign ramp = field4(startup_reg, MSR_RAMP_LSB);
  assign hold_code = field4(startup_reg, MSR_HOLDT_LSB);
  assign hold_ilim = startup_reg[MSR_ILIM_LSB +: 5];
  assign freq_code = startup_reg[MSR_FREQ_LSB +: 3];
  assign thr = startup_reg[MSR_THR_LSB +: 7];
  assign rls = startup_reg[MSR_RLS_BIT];
  assign adv = startup_reg[MSR_ADV_LSB +: 2];

  // Parameter source during reverse drive
  logic use_reverse;
  logic [4:0] eff_cur_next;
  logic [3:0] eff_lin_next;
  logic [3:0] eff_quad_next;

  assign use_reverse = i_reverse_active && rev_src_sel; // see RQ3
  assign eff_cur_next = use_reverse ? i_rev_open_loop_current : i_fwd_open_loop_current;
  assign eff_lin_next = use_reverse ? rev_lin : i_fwd_linear_accel_coef;
  assign eff_quad_next = use_reverse ? rev_quad : i_fwd_quadratic_accel_coef;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_eff_open_loop_current <= 5'h00;
      o_eff_linear_accel_coef <= 4'h0;
      o_eff_quadratic_accel_coef <= 4'h0;
    end
    else
    begin
      o_eff_open_loop_current <= eff_cur_next; // see RQ3
      o_eff_linear_accel_coef <= eff_lin_next; // see RQ4
      o_eff_quadratic_accel_coef <= eff_quad_next; // see RQ5
    end
  end

  // Decoded start-up method
  logic m_single;
  logic m_double;
  logic m_pulse;
  logic m_slow;

  assign m_single = (method == MSR_METHOD_SINGLE_HOLD); // see RQ6
  assign m_double = (method == MSR_METHOD_DOUBLE_HOLD); // see RQ6
  assign m_pulse = (method == MSR_METHOD_PULSE_DETECT); // see RQ6
  assign m_slow = (method == MSR_METHOD_SLOW_CYCLE); // see RQ6

  // Advance angle in degrees
  logic [6:0] adv_deg;
  assign adv_deg = 7'(adv * MSR_ADV_STEP_DEG); // see RQ13

  // Field outputs come straight from the register flops
  assign o_reverse_param_source_sel = rev_src_sel;
  assign o_startup_method_sel = method;
  assign o_ramp_rate_code = ramp;
  assign o_hold_time_code = hold_code;
  assign o_hold_current_limit = hold_ilim; // see RQ9
  assign o_position_pulse_frequency = freq_code;
  assign o_position_pulse_current_threshold = thr;
  assign o_position_release_style = rls; // see RQ12
  assign o_position_advance_angle = adv;
  assign o_startup_low_bits = startup_reg[MSR_LOW_LSB +: 4];

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_method_single_hold <= 1'b0;
      o_method_double_hold <= 1'b0;
      o_method_pulse_detect <= 1'b0;
      o_method_slow_cycle <= 1'b0;
      o_ramp_unlimited <= 1'b0;
      o_position_advance_deg <= 7'h00;
    end
    else
    begin
      o_method_single_hold <= m_single;
      o_method_double_hold <= m_double;
      o_method_pulse_detect <= m_pulse;
      o_method_slow_cycle <= m_slow;
      o_ramp_unlimited <= (ramp == MSR_RAMP_UNLIMITED); // see RQ7
      o_position_advance_deg <= adv_deg; // see RQ13
    end
  end

  // Detection pulse period per code, folded at elaboration
  logic [31:0] pulse_cyc [8];
  for (genvar g = 0; g < 8; g++)
  begin : g_pulse
    localparam int CYC = P_CLK_HZ / MSR_PULSE_HZ[g];
    assign pulse_cyc[g] = CYC[31:0];
  end

  // Hold length in milliseconds per code
  logic [13:0] hold_ms [16];
  for (genvar h = 0; h < 16; h++)
  begin : g_hold
    localparam int MS = MSR_HOLD_MS[h];
    assign hold_ms[h] = MS[13:0];
  end

  // Detection pulse train runs while asked for and the method is pulse detection
  logic pulse_run;
  assign pulse_run = i_position_detect_run && m_pulse;

  msr_rate_tick #(
    .CNT_W(32)
  ) u_pulse_tick (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_enable(pulse_run),
    .i_period_cycles(pulse_cyc[freq_code]), // see RQ10
    .o_tick(o_position_pulse)
  );

  // Threshold compare, fraction of base current in 1/128 steps
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_position_over_threshold <= 1'b0;
    end
    else
    begin
      o_position_over_threshold <= pulse_run && (i_phase_current_frac >= thr); // see RQ11
    end
  end

  // Orientation hold timer
  msr_hold_state_t hold_state_reg;
  msr_hold_state_t hold_state_next;
  logic [13:0] hold_count_reg;
  logic [13:0] hold_count_next;
  logic [13:0] hold_target_reg;
  logic ms_tick;
  logic hold_expire;

  msr_rate_tick #(
    .CNT_W(32)
  ) u_ms_tick (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_enable(hold_state_reg == MSR_HOLD_RUN),
    .i_period_cycles(MS_CYCLES),
    .o_tick(ms_tick)
  );

  assign hold_expire = ms_tick && (hold_count_reg + 14'h0001 >= hold_target_reg);

  always_comb
  begin
    hold_state_next = hold_state_reg;
    hold_count_next = hold_count_reg;
    case (hold_state_reg)
      MSR_HOLD_IDLE:
      begin
        hold_count_next = 14'h0000;
        if (i_hold_start)
        begin
          hold_state_next = MSR_HOLD_RUN;
        end
      end
      MSR_HOLD_RUN:
      begin
        if (hold_expire)
        begin
          hold_state_next = MSR_HOLD_END;
        end
        else if (ms_tick)
        begin
          hold_count_next = hold_count_reg + 14'h0001;
        end
      end
      MSR_HOLD_END:
      begin
        hold_state_next = MSR_HOLD_IDLE;
        hold_count_next = 14'h0000;
      end
      default:
      begin
        hold_state_next = MSR_HOLD_IDLE;
        hold_count_next = 14'h0000;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hold_state_reg <= MSR_HOLD_IDLE;
      hold_count_reg <= 14'h0000;
      hold_target_reg <= 14'h0000;
    end
    else
    begin
      hold_state_reg <= hold_state_next;
      hold_count_reg <= hold_count_next;
      // Length latched at start so a rewrite cannot cut a hold short
      if (hold_state_reg == MSR_HOLD_IDLE && i_hold_start)
      begin
        hold_target_reg <= hold_ms[hold_code]; // see RQ8
      end
    end
  end

  assign o_hold_busy = (hold_state_reg == MSR_HOLD_RUN);
  assign o_hold_done = (hold_state_reg == MSR_HOLD_END);

  // Read-only status
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[MSR_ST_HOLD_BUSY_BIT] = o_hold_busy;
    status_word[MSR_ST_HOLD_DONE_BIT] = o_hold_done;
    status_word[MSR_ST_REV_EFF_BIT] = use_reverse;
    status_word[MSR_ST_PULSE_RUN_BIT] = pulse_run;
    status_word[MSR_ST_OVER_THR_BIT] = o_position_over_threshold;
  end

endmodule : msr_startup_regs
`default_nettype wire

/* File: verilog/msr_pkg.sv */
// Package: offsets, field layout, reset values and rate tables for the start-up settings bank
`default_nettype none
package msr_pkg;

  localparam int MSR_ADDR_W = 8;
  localparam int MSR_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] MSR_REVERSE_OFS = 8'h38;
  localparam logic [7:0] MSR_STARTUP_OFS = 8'h3C;
  localparam logic [7:0] MSR_STATUS_OFS = 8'h7C;

  // Values after reset
  localparam logic [31:0] MSR_REVERSE_RST = 32'h0000_0000;
  localparam logic [31:0] MSR_STARTUP_RST = 32'h0000_0000;

  // Writable bits; the rest read as zero
  localparam logic [31:0] MSR_REVERSE_WMASK = 32'h1FF0_0000;
  localparam logic [31:0] MSR_STARTUP_WMASK = 32'hFFFF_FFFF;

  // Reverse word layout
  localparam int MSR_REV_SRC_BIT = 28;
  localparam int MSR_REV_LIN_LSB = 24;
  localparam int MSR_REV_QUAD_LSB = 20;

  // Start-up word layout
  localparam int MSR_METHOD_LSB = 30;
  localparam int MSR_RAMP_LSB = 26;
  localparam int MSR_HOLDT_LSB = 22;
  localparam int MSR_ILIM_LSB = 17;
  localparam int MSR_FREQ_LSB = 14;
  localparam int MSR_THR_LSB = 7;
  localparam int MSR_RLS_BIT = 6;
  localparam int MSR_ADV_LSB = 4;
  localparam int MSR_LOW_LSB = 0;

  // Status word layout
  localparam int MSR_ST_HOLD_BUSY_BIT = 0;
  localparam int MSR_ST_HOLD_DONE_BIT = 1;
  localparam int MSR_ST_REV_EFF_BIT = 2;
  localparam int MSR_ST_PULSE_RUN_BIT = 3;
  localparam int MSR_ST_OVER_THR_BIT = 4;

  // Start-up method codes
  localparam logic [1:0] MSR_METHOD_SINGLE_HOLD = 2'h0;
  localparam logic [1:0] MSR_METHOD_DOUBLE_HOLD = 2'h1;
  localparam logic [1:0] MSR_METHOD_PULSE_DETECT = 2'h2;
  localparam logic [1:0] MSR_METHOD_SLOW_CYCLE = 2'h3;

  localparam logic [3:0] MSR_RAMP_UNLIMITED = 4'hF;
  localparam logic [6:0] MSR_ADV_STEP_DEG = 7'h1E;

  // Hold time base: one millisecond, in microseconds
  localparam int MSR_MS_TIME_US = 1000;
  localparam int MSR_US_PER_S = 1000000;

  // Detection pulse rates in Hz, per code
  localparam int MSR_PULSE_HZ [8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};

  // Hold durations in ms, per code
  localparam int MSR_HOLD_MS [16] = '{10, 50, 100, 200, 300, 400, 500, 750,
                                      1000, 1500, 2000, 3000, 4000, 5000, 7500, 10000};

endpackage : msr_pkg
`default_nettype wire

/* File: verilog/msr_rate_tick.sv */
// Module: divider that gives a one-cycle enable pulse every period
`timescale 1ns/1ps
`default_nettype none
module msr_rate_tick #(
  parameter int CNT_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic [CNT_W-1:0] i_period_cycles,
  output logic o_tick
);
  import msr_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic wrap;

  // Period of zero or one still ticks every cycle
  assign wrap = i_enable && (count_reg + 1'b1 >= i_period_cycles);
  assign count_next = !i_enable ? '0 : (wrap ? '0 : count_reg + 1'b1);

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      count_reg <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      o_tick <= wrap;
    end
  end

endmodule : msr_rate_tick
`default_nettype wire

/* File: sim/msr_startup_regs_chk.sv */
// Checker: concurrent properties on the settings bank ports
`timescale 1ns/1ps
`default_nettype none
module msr_startup_regs_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_reverse_active,
  input wire logic [4:0] i_fwd_open_loop_current,
  input wire logic [4:0] i_rev_open_loop_current,
  input wire logic [4:0] o_eff_open_loop_current,
  input wire logic o_reverse_param_source_sel,
  input wire logic [1:0] o_startup_method_sel,
  input wire logic o_method_pulse_detect,
  input wire logic [3:0] o_ramp_rate_code,
  input wire logic o_ramp_unlimited,
  input wire logic [1:0] o_position_advance_angle,
  input wire logic [6:0] o_position_advance_deg,
  input wire logic o_hold_busy,
  input wire logic o_hold_done,
  input wire logic o_position_pulse,
  input wire logic i_position_detect_run,
  input wire logic [6:0] i_phase_current_frac,
  input wire logic [6:0] o_position_pulse_current_threshold,
  input wire logic o_position_over_threshold
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  AST_REV_RSVD: assert property (i_rd && i_addr == 8'h38 |=> o_rdata[31:29] == 3'h0 && o_rdata[19:0] == 20'h0) else $error("reverse word reserved bits not zero");
  AST_REV_SRC: assert property (i_wr && i_addr == 8'h38 |=> o_reverse_param_source_sel == $past(i_wdata[28])) else $error("source select not written");
  AST_EFF_CUR: assert property ($past(i_reset_n) |-> o_eff_open_loop_current ==
    ($past(i_reverse_active && o_reverse_param_source_sel) ? $past(i_rev_open_loop_current) :
    $past(i_fwd_open_loop_current))) else $error("wrong open-loop current source");
  AST_METHOD_WR: assert property (i_wr && i_addr == 8'h3C |=> o_startup_method_sel == $past(i_wdata[31:30])) else $error("method field not written");
  AST_PULSE_DEC: assert property (o_method_pulse_detect == ($past(o_startup_method_sel) == 2'h2)) else $error("pulse method decode wrong");
  AST_RAMP_UNLIM: assert property (o_ramp_unlimited == ($past(o_ramp_rate_code) == 4'hF)) else $error("unlimited ramp flag wrong");
  AST_HOLD_END: assert property ($rose(o_hold_done) |-> $past(o_hold_busy) && !o_hold_busy ##1 !o_hold_done) else $error("hold end sequence wrong");
  AST_THR_CMP: assert property (o_position_over_threshold == $past(i_position_detect_run && o_startup_method_sel == 2'h2 && i_phase_current_frac >= o_position_pulse_current_threshold)) else $error("threshold compare wrong");
  AST_ADV_DEG: assert property (o_position_advance_deg == 7'($past(o_position_advance_angle)) * 7'h1E) else $error("advance angle degrees wrong");

  COV_HOLD: cover property (o_hold_busy ##1 o_hold_done);
  COV_PULSE: cover property (o_method_pulse_detect && o_position_pulse);
  COV_OVER: cover property (o_position_over_threshold);
endmodule : msr_startup_regs_chk
`default_nettype wire

bind msr_startup_regs msr_startup_regs_chk u_chk (.*);

/* File: sim/msr_startup_regs_tb.sv */
// Testbench: directed scenarios for the settings bank
`timescale 1ns/1ps
`default_nettype none
module msr_startup_regs_tb;
  import msr_pkg::*;
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic i_reverse_active = 1'b0, i_hold_start = 1'b0, i_position_detect_run = 1'b0;
  logic [4:0] i_fwd_open_loop_current = 5'h03, i_rev_open_loop_current = 5'h1C;
  logic [3:0] i_fwd_linear_accel_coef = 4'h2, i_fwd_quadratic_accel_coef = 4'h6;
  logic [6:0] i_phase_current_frac = 7'h00;
  logic [4:0] eff_cur, ilim;
  logic [3:0] eff_lin, eff_quad, ramp, holdt, low;
  logic src, single, dbl, pulse_m, slow, unlim, rls, hbusy, hdone, ppulse, over;
  logic [1:0] meth, adv;
  logic [2:0] freq;
  logic [6:0] thr, deg;
  int failures = 0, n_tests = 0;

  always #50 i_sys_clk = ~i_sys_clk;

  msr_startup_regs #(.P_CLK_HZ(100000)) uut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_reverse_active(i_reverse_active),
    .i_fwd_open_loop_current(i_fwd_open_loop_current),
    .i_fwd_linear_accel_coef(i_fwd_linear_accel_coef),
    .i_fwd_quadratic_accel_coef(i_fwd_quadratic_accel_coef),
    .i_rev_open_loop_current(i_rev_open_loop_current), .i_hold_start(i_hold_start),
    .i_position_detect_run(i_position_detect_run), .i_phase_current_frac(i_phase_current_frac),
    .o_eff_open_loop_current(eff_cur), .o_eff_linear_accel_coef(eff_lin),
    .o_eff_quadratic_accel_coef(eff_quad), .o_reverse_param_source_sel(src),
    .o_startup_method_sel(meth), .o_method_single_hold(single), .o_method_double_hold(dbl),
    .o_method_pulse_detect(pulse_m), .o_method_slow_cycle(slow), .o_ramp_rate_code(ramp),
    .o_ramp_unlimited(unlim), .o_hold_time_code(holdt), .o_hold_current_limit(ilim),
    .o_position_pulse_frequency(freq), .o_position_pulse_current_threshold(thr),
    .o_position_release_style(rls), .o_position_advance_angle(adv),
    .o_position_advance_deg(deg), .o_startup_low_bits(low), .o_hold_busy(hbusy),
    .o_hold_done(hdone), .o_position_pulse(ppulse), .o_position_over_threshold(over)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_rdata, exp);
  endtask : rd

  // Lets one-cycle-lag outputs land
  task automatic settle();
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask : settle

  task automatic t_reset();
    rd(8'h38, 32'h0);
    rd(8'h3C, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_reverse();
    wr(8'h38, 32'hFFFF_FFFF);
    rd(8'h38, 32'h1FF0_0000);
    wr(8'h38, 32'h1A50_0000);
    i_reverse_active <= 1'b1;
    settle();
    chk({src, eff_cur, eff_lin, eff_quad}, {1'b1, 5'h1C, 4'hA, 4'h5});
    wr(8'h38, 32'h0A50_0000);
    settle();
    chk({src, eff_cur, eff_lin, eff_quad}, {1'b0, 5'h03, 4'h2, 4'h6});
    @(posedge i_sys_clk);
    i_reverse_active <= 1'b0;
    $display("test reverse done");
  endtask : t_reverse

  task automatic t_startup();
    logic [31:0] w;
    for (int i = 0; i < 4; i++)
    begin
      w = {i[1:0], 4'hF - 4'(i), 4'(i * 5), 5'(i * 9), 3'(i + 4), 7'(i * 37), i[0], i[1:0], 4'(i)};
      wr(8'h3C, w);
      rd(8'h3C, w);
      settle();
      chk({meth, ramp, holdt, ilim, freq, thr, rls, adv, low}, w);
      chk({slow, pulse_m, dbl, single}, 32'(1 << i));
      chk({unlim, deg}, {i == 0, 7'(i * 30)});
    end
    wr(8'h40, 32'h1234_5678);
    rd(8'h40, 32'h0);
    rd(8'h3C, w);
    $display("test startup done");
  endtask : t_startup

  task automatic t_hold();
    int n;
    wr(8'h3C, 32'h0000_0000);
    @(posedge i_sys_clk);
    i_hold_start <= 1'b1;
    @(posedge i_sys_clk);
    i_hold_start <= 1'b0;
    @(negedge i_sys_clk);
    chk(hbusy, 1'b1);
    n = 1;
    while (hdone !== 1'b1 && n < 1100)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(32'(n >= 999 && n <= 1004), 32'h1);
    chk({hbusy, hdone}, 2'b01);
    $display("test hold done");
  endtask : t_hold

  task automatic t_pulse();
    int n;
    wr(8'h3C, 32'h8001_E040);
    @(posedge i_sys_clk);
    i_position_detect_run <= 1'b1;
    i_phase_current_frac <= 7'h3F;
    n = 0;
    repeat (105)
    begin
      @(negedge i_sys_clk);
      if (ppulse === 1'b1) n++;
    end
    chk(32'(n), 32'hA);
    chk({over, rls}, 2'b01);
    @(posedge i_sys_clk);
    i_phase_current_frac <= 7'h40;
    settle();
    chk(over, 1'b1);
    rd(8'h7C, 32'h0000_0018);
    @(posedge i_sys_clk);
    i_position_detect_run <= 1'b0;
    $display("test pulse done");
  endtask : t_pulse

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #(20000 * 100);
    failures++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_reverse();
    t_startup();
    t_hold();
    t_pulse();
    finish_test();
  end
endmodule : msr_startup_regs_tb
`default_nettype wire
